// ### hw/tcf_pkg.sv
// Package of constants for the timer count read and input filter block.
package tcf_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_RELOAD   = 8'h04;
  localparam logic [7:0] ADDR_CNT_HIGH = 8'h08;
  localparam logic [7:0] ADDR_CNT_LOW  = 8'h0c;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;
  localparam logic [7:0] ADDR_MASK     = 8'h14;

  // ----------------------------------------------------------------
  // Control field positions and reset values
  // ----------------------------------------------------------------
  localparam int          CTRL_EN_BIT    = 0;
  localparam int          CTRL_UPDN_BIT  = 1;
  localparam int          CTRL_NOISE_FILTER_ENABLE_BIT  = 2;
  localparam int          CTRL_WSEL_LSB  = 4;
  localparam int          FILT_MIN_WIDTH = 4;
  localparam int          FILT_MAX_WIDTH = 11;
  localparam logic [15:0] RELOAD_RST     = 16'hffff;
  localparam logic [15:0] CNT_RST        = 16'h0000;
  localparam logic [15:0] CNT_START      = 16'h0001;

  // Status bits: 0 = reload event, 1 = down count reached zero.
  localparam int          ST_RELOAD_BIT  = 0;
  localparam int          ST_ZERO_BIT    = 1;
  localparam int          ST_WIDTH       = 2;

  // AXI responses.
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef enum logic {TCF_DIR_UP, TCF_DIR_DOWN} tcf_dir_t;

endpackage

// ### hw/tcf_timer.sv
// Timer slice with latched count reads, output toggle and input noise filter.
`timescale 1ns/1ns
// What this block does
// - Software may read the running count; reads never disturb counting.
// - Reading count high byte while enabled copies the live low byte to a hold.
// - Next low byte read after that returns the held value.
// - When disabled, low byte reads return the live counter value.
// - Timer output pin toggles every time the counter reloads.
// - Timer input is synchronized to the timer clock before use.
// - Filter enable 0 bypasses the noise filter; 1 inserts it.
// - Filter is an up/down saturating counter, 4 to 11 bits wide.
// - Width select codes 000..111 give widths 4..11 bits.
// - Filter output has hysteresis, not following single count steps.
// - Active-low saturated flag indicates noise on the timer input.
// - Filter keeps running in stop mode.
// - Up/down mode counts up to reload, down to zero, repeats.
// - Up/down period is twice the reload value.
// - Up/down mode raises an interrupt when the count decrements to zero.
module tcf_timer
  import tcf_pkg::*;
#(
  parameter int FILT_W = FILT_MAX_WIDTH
)
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Timer pins and filter straps
  input  wire logic        timer_in,
  input  wire logic        noise_filter_enable,
  input  wire logic [2:0]  filter_width_select,
  input  wire logic        stop_mode,
  output logic             timer_out,
  output logic             timer_in_filtered,
  output logic             filter_saturated_n,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic        aw_ff;
  logic [7:0]  awaddr_ff;
  logic        w_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        wr_go;
  logic        rd_go;
  logic        en_ff;
  logic        updn_ff;
  logic [15:0] reload_ff;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  tcf_dir_t    dir_ff;
  tcf_dir_t    nxt_dir;
  logic        reload_ev;
  logic        zero_ev;
  logic [7:0]  hold_ff;
  logic        hold_vld_ff;
  logic [ST_WIDTH-1:0] status_ff;
  logic [ST_WIDTH-1:0] mask_ff;
  logic [ST_WIDTH-1:0] evt;
  logic [ST_WIDTH-1:0] clr;
  logic        sync1_ff;
  logic        sync2_ff;
  logic [FILT_W-1:0] fcnt_ff;
  logic [FILT_W-1:0] fmax;
  logic        fout_ff;
  logic        sel_in;

  // Width select decoder: all ones in the low (4 + code) bits.
  function automatic logic [FILT_W-1:0] filt_max(input logic [2:0] code);
    logic [FILT_W-1:0] m;
    m = '0;
    for (int i = 0; i < FILT_W; i++)
    begin
      if (i < FILT_MIN_WIDTH + int'(code))
      begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign wr_go = aw_ff && w_ff && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  // Address and data are captured in either order; the response follows both.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_ff         <= 1'b0;
      w_ff          <= 1'b0;
      awaddr_ff     <= 8'h00;
      wdata_ff      <= 32'h00000000;
      wstrb_ff      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_ff && !s_axi_awready && !s_axi_awvalid ? 1'b1 : !aw_ff;
      s_axi_wready  <= !w_ff;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_ff         <= 1'b1;
        awaddr_ff     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_ff         <= 1'b1;
        wdata_ff     <= s_axi_wdata;
        wstrb_ff     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_ff        <= 1'b0;
        w_ff         <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_ff == ADDR_CTRL || awaddr_ff == ADDR_RELOAD ||
                         awaddr_ff == ADDR_STATUS || awaddr_ff == ADDR_MASK ||
                         awaddr_ff == ADDR_CNT_HIGH || awaddr_ff == ADDR_CNT_LOW)
                        ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one read at a time, data registered one cycle after acceptance.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !rd_go;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        case (s_axi_araddr)
          ADDR_CTRL:
            s_axi_rdata <= {25'h0, filter_width_select, 1'b0, en_ff ? 1'b0 : 1'b0,
                            updn_ff, en_ff} | 32'h0;
          ADDR_RELOAD:   s_axi_rdata <= {16'h0, reload_ff};
          ADDR_CNT_HIGH: s_axi_rdata <= {24'h0, cnt_ff[15:8]};
          // Held byte only while enabled and latched; otherwise the live byte.
          ADDR_CNT_LOW:  s_axi_rdata <= {24'h0, (en_ff && hold_vld_ff) ? hold_ff
                                                 : cnt_ff[7:0]};
          ADDR_STATUS:   s_axi_rdata <= {30'h0, status_ff};
          ADDR_MASK:     s_axi_rdata <= {30'h0, mask_ff};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_ff     <= 1'b0;
      updn_ff   <= 1'b0;
      reload_ff <= RELOAD_RST;
      mask_ff   <= '0;
    end
    else if (wr_go)
    begin
      if (awaddr_ff == ADDR_CTRL && wstrb_ff[0])
      begin
        en_ff   <= wdata_ff[CTRL_EN_BIT];
        updn_ff <= wdata_ff[CTRL_UPDN_BIT];
      end
      if (awaddr_ff == ADDR_RELOAD)
      begin
        if (wstrb_ff[0]) reload_ff[7:0]  <= wdata_ff[7:0];
        if (wstrb_ff[1]) reload_ff[15:8] <= wdata_ff[15:8];
      end
      if (awaddr_ff == ADDR_MASK && wstrb_ff[0])
      begin
        mask_ff <= wdata_ff[ST_WIDTH-1:0];
      end
    end
  end

  // Low byte hold: loaded on a high byte read, released by the low byte read.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hold_ff     <= 8'h00;
      hold_vld_ff <= 1'b0;
    end
    else if (rd_go && s_axi_araddr == ADDR_CNT_HIGH && en_ff)
    begin
      hold_ff     <= cnt_ff[7:0];
      hold_vld_ff <= 1'b1;
    end
    else if ((rd_go && s_axi_araddr == ADDR_CNT_LOW) || !en_ff)
    begin
      hold_vld_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Counter; reads only sample it, so counting never depends on bus reads
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_cnt   = cnt_ff;
    nxt_dir   = dir_ff;
    reload_ev = 1'b0;
    zero_ev   = 1'b0;
    if (en_ff && !updn_ff)
    begin
      // Continuous mode: count to reload, then restart at one.
      if (cnt_ff >= reload_ff)
      begin
        nxt_cnt   = CNT_START;
        reload_ev = 1'b1;
      end
      else
      begin
        nxt_cnt = cnt_ff + 16'h0001;
      end
    end
    else if (en_ff)
    begin
      // Up/down mode: reload steps up plus reload steps down gives 2 x reload.
      if (dir_ff == TCF_DIR_UP)
      begin
        if (cnt_ff >= reload_ff)
        begin
          nxt_dir   = TCF_DIR_DOWN;
          nxt_cnt   = cnt_ff - 16'h0001;
          reload_ev = 1'b1;
        end
        else
        begin
          nxt_cnt = cnt_ff + 16'h0001;
        end
      end
      else
      begin
        nxt_cnt = cnt_ff - 16'h0001;
        if (cnt_ff == CNT_START)
        begin
          nxt_dir = TCF_DIR_UP;
          zero_ev = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_ff <= CNT_RST;
      dir_ff <= TCF_DIR_UP;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      dir_ff <= nxt_dir;
    end
  end

  // Output pin toggles on every reload.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_out <= 1'b0;
    end
    else if (reload_ev)
    begin
      timer_out <= !timer_out;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status: set wins over write-one-to-clear
  // ----------------------------------------------------------------
  assign evt = {zero_ev, reload_ev};
  assign clr = (wr_go && awaddr_ff == ADDR_STATUS && wstrb_ff[0])
               ? wdata_ff[ST_WIDTH-1:0] : '0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_ff <= '0;
      irq       <= 1'b0;
    end
    else
    begin
      status_ff <= (status_ff & ~clr) | evt;
      irq       <= |(((status_ff & ~clr) | evt) & mask_ff);
    end
  end

  // ----------------------------------------------------------------
  // Input noise filter; free of stop_mode so it runs in stop
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= timer_in;
      sync2_ff <= sync1_ff;
    end
  end

  assign fmax   = filt_max(filter_width_select);
  assign sel_in = noise_filter_enable ? fout_ff : sync2_ff;

  // Saturating counter; output moves only at the extremes, giving hysteresis.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fcnt_ff            <= '0;
      fout_ff            <= 1'b0;
      filter_saturated_n <= 1'b1;
      timer_in_filtered  <= 1'b0;
    end
    else
    begin
      if (sync2_ff && fcnt_ff < fmax)
      begin
        fcnt_ff <= fcnt_ff + 1'b1;
      end
      else if (!sync2_ff && fcnt_ff > fmax)
      begin
        fcnt_ff <= fmax;
      end
      else if (!sync2_ff && fcnt_ff != '0)
      begin
        fcnt_ff <= fcnt_ff - 1'b1;
      end
      if (fcnt_ff >= fmax)
      begin
        fout_ff <= 1'b1;
      end
      else if (fcnt_ff == '0)
      begin
        fout_ff <= 1'b0;
      end
      // Low while the counter sits at neither extreme: input is noisy.
      filter_saturated_n <= (fcnt_ff == '0) || (fcnt_ff >= fmax);
      timer_in_filtered  <= sel_in;
    end
  end

endmodule

// ### tb/tcf_timer_props.sv
// Checker holding the concurrent assertions on the timer slice ports.
`timescale 1ns/1ns
module tcf_timer_props (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus handshakes
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Timer pins
  input wire logic        timer_in,
  input wire logic        noise_filter_enable,
  input wire logic [2:0]  filter_width_select,
  input wire logic        timer_in_filtered,
  input wire logic        filter_saturated_n,
  input wire logic        timer_out,
  input wire logic        irq
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Filter running at its narrowest width with a steady input level.
  sequence s_hi;
    noise_filter_enable && filter_width_select == 3'h0 && timer_in;
  endsequence
  sequence s_lo;
    noise_filter_enable && filter_width_select == 3'h0 && !timer_in;
  endsequence

  // Reset is checked on its own, so it cannot use the default disable.
  property p_rst;
    disable iff (1'h0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !timer_out && !irq
      && filter_saturated_n && !timer_in_filtered;
  endproperty
  a_rst: assert property (p_rst) else $error("Outputs not idle after reset."); // Reset state.
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("Write response dropped early."); // Bus.
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("Read data not held."); // Bus.
  property p_rlat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("Read answer late."); // Bus.
  property p_arblk;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_arblk: assert property (p_arblk) else $error("Read taken while busy."); // Bus.
  property p_byp;
    (!noise_filter_enable && $stable(timer_in)) [*5] |-> timer_in_filtered == timer_in;
  endproperty
  a_byp: assert property (p_byp) else $error("Bypass path wrong.");
  property p_filt_hi;
    s_hi [*8] ##1 s_hi [*8] ##1 s_hi [*6] |-> timer_in_filtered && filter_saturated_n;
  endproperty
  a_filt_hi: assert property (p_filt_hi) else $error("Filter not high.");
  property p_filt_lo;
    s_lo [*8] ##1 s_lo [*8] ##1 s_lo [*6] |-> !timer_in_filtered && filter_saturated_n;
  endproperty
  a_filt_lo: assert property (p_filt_lo) else $error("Filter not low.");
endmodule

bind tcf_timer tcf_timer_props u_props (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .timer_in,
  .noise_filter_enable, .filter_width_select, .timer_in_filtered, .filter_saturated_n,
  .timer_out, .irq);

// ### tb/tcf_pin_model.sv
// Model of the external timer pins: drives the input and times the output.
`timescale 1ns/1ns
module tcf_pin_model (
  // Clock
  input wire logic         aclk,
  // Bench request and pins
  input wire logic         pin_level,
  input wire logic         timer_out,
  output logic             timer_in   = 1'h0,
  output logic [15:0]      out_period = 16'h0000
);
  // ----------------------------------------------------------------
  // Pin behaviour
  // ----------------------------------------------------------------
  // Known values before the first edge; the clocked process is the only writer.
  logic [15:0] gap_ff  = 16'h0000;
  logic        last_ff = 1'h0;

  // The pin follows the request one edge late; the gap between output changes is kept.
  always @(posedge aclk)
  begin
    timer_in <= pin_level;
    last_ff  <= timer_out;
    gap_ff   <= (timer_out != last_ff) ? 16'h0001 : gap_ff + 16'h0001;
    if (timer_out != last_ff)
      out_period <= gap_ff;
  end
endmodule

// ### tb/tcf_timer_tb.sv
// Self-checking bench for the timer slice.
`timescale 1ns/1ns
module tcf_timer_tb;
  import tcf_pkg::*;
  // ----------------------------------------------------------------
  // Signals, tasks and stimulus
  // ----------------------------------------------------------------
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} tcf_note_t;
  logic        aclk                = 1'h0;
  logic        aresetn             = 1'h0;
  logic [7:0]  s_axi_awaddr        = 8'h00;
  logic        s_axi_awvalid       = 1'h0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata         = 32'h0;
  logic [3:0]  s_axi_wstrb         = 4'hf;
  logic        s_axi_wvalid        = 1'h0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready        = 1'h0;
  logic [7:0]  s_axi_araddr        = 8'h00;
  logic        s_axi_arvalid       = 1'h0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready        = 1'h0;
  logic        timer_in;
  logic        noise_filter_enable = 1'h0;
  logic [2:0]  filter_width_select = 3'h0;
  logic        stop_mode           = 1'h0;
  logic        timer_out;
  logic        timer_in_filtered;
  logic        filter_saturated_n;
  logic        irq;
  logic        pin_level           = 1'h0;
  logic [15:0] out_period;
  tcf_note_t   notes[$];
  tcf_note_t   nt;
  int          n_errors            = 0;
  int          checks_done         = 0;

  tcf_timer DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .timer_in, .noise_filter_enable, .filter_width_select, .stop_mode,
    .timer_out, .timer_in_filtered, .filter_saturated_n, .irq);
  tcf_pin_model u_pins (.aclk, .pin_level, .timer_out, .timer_in, .out_period);

  // Clock of 50 ns.
  initial
  begin
    forever #25 aclk = ~aclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Address and data go out together and each drops once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    check(32'(s_axi_bresp), 32'(r), "bresp");
  endtask

  // The expected answer is noted before the request; the monitor compares it.
  task automatic rd(input logic [7:0] a, input tcf_note_t n, output logic [31:0] q);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    notes.push_back(n);
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    q = s_axi_rdata;
    s_axi_rready <= 1'h0;
  endtask

  // Oldest note against each read answer; a zero mask leaves the data unchecked.
  always @(posedge aclk)
    if (s_axi_rvalid && s_axi_rready)
    begin
      nt = notes.pop_front();
      check(s_axi_rdata & nt.m, nt.d, "rdata");
      check(32'(s_axi_rresp), 32'(nt.r), "rresp");
    end

  // Watchdog well beyond the roughly 12000 cycles the sequence needs.
  initial
  begin
    #3000000;
    n_errors++;
    give_verdict();
  end

  // Main sequence.
  initial
  begin
    logic [31:0] q, h1, l1, h2, l2;
    logic        f_ok, sat_lo;
    logic [15:0] rl;
    time         t1, t2;
    int          d[8];
    int          n;
    void'($urandom(94));
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    rd(ADDR_RELOAD, '{32'h0000ffff, '1, RESP_OKAY}, q);
    rd(8'h18, '{32'h0, '1, RESP_SLVERR}, q);
    wr(8'h18, 32'h0, RESP_SLVERR);
    rd(ADDR_CNT_LOW, '{32'h0, 32'hff, RESP_OKAY}, q);
    // A short low glitch must not move a saturated filter, but flags noise.
    stop_mode <= 1'h1;
    noise_filter_enable <= 1'h1;
    pin_level <= 1'h1;
    repeat (30) @(posedge aclk);
    check(32'(timer_in_filtered), 32'h1, "filtered high");
    pin_level <= 1'h0;
    repeat ($urandom_range(5, 1)) @(posedge aclk);
    pin_level <= 1'h1;
    f_ok = 1'h1;
    sat_lo = 1'h0;
    repeat (20)
    begin
      @(posedge aclk);
      f_ok &= timer_in_filtered;
      sat_lo |= !filter_saturated_n;
    end
    check(32'(f_ok), 32'h1, "hysteresis");
    check(32'(sat_lo), 32'h1, "noise flag");
    // Each width code: the rise delay grows by the difference of saturation values.
    for (int s = 0; s < 8; s++)
    begin
      pin_level <= 1'h0;
      repeat ((16 << s) + 20) @(posedge aclk);
      filter_width_select <= 3'(s);
      rd(ADDR_CTRL, '{32'(s) << CTRL_WSEL_LSB, 32'h70, RESP_OKAY}, q);
      pin_level <= 1'h1;
      n = 0;
      while (timer_in_filtered !== 1'h1 && n < 3000)
      begin
        @(posedge aclk);
        n++;
      end
      d[s] = n;
      if (s > 0)
        check(32'(d[s] - d[s-1]), 32'(8 << s), "filter step");
    end
    check(32'(d[0] >= 15), 32'h1, "narrow delay");
    // Bypass with random levels of random length.
    pin_level <= 1'h0;
    repeat (2100) @(posedge aclk);
    noise_filter_enable <= 1'h0;
    repeat (60)
    begin
      pin_level <= 1'($urandom);
      repeat ($urandom_range(8, 1)) @(posedge aclk);
    end
    repeat (8) @(posedge aclk);
    check(32'(timer_in_filtered), 32'(pin_level), "bypass");
    // Continuous period, then the zero interrupt, then the up/down period.
    rl = 16'($urandom_range(60, 20));
    wr(ADDR_RELOAD, 32'(rl), RESP_OKAY);
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    repeat (3 * rl) @(posedge aclk);
    check(32'(out_period), 32'(rl), "period");
    wr(ADDR_CTRL, 32'h3, RESP_OKAY);
    wr(ADDR_MASK, 32'h2, RESP_OKAY);
    for (n = 0; n < 300 && irq !== 1'h1; n++)
      @(posedge aclk);
    check(32'(irq), 32'h1, "zero irq");
    repeat (5 * rl) @(posedge aclk);
    check(32'(out_period), 32'(2 * rl), "updown period");
    rd(ADDR_STATUS, '{32'h3, 32'h3, RESP_OKAY}, q);
    wr(ADDR_MASK, 32'h0, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check(32'(irq), 32'h0, "masked irq");
    wr(ADDR_MASK, 32'h2, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check(32'(irq), 32'h1, "sticky irq");
    // Coherent count: the held low byte stays put while the counter runs.
    wr(ADDR_RELOAD, 32'hffff, RESP_OKAY);
    repeat (2 * rl + 10) @(posedge aclk);
    rd(ADDR_CNT_HIGH, '{32'h0, 32'h0, RESP_OKAY}, h1);
    t1 = $time;
    repeat (40) @(posedge aclk);
    rd(ADDR_CNT_LOW, '{32'h0, 32'h0, RESP_OKAY}, l1);
    repeat (300) @(posedge aclk);
    rd(ADDR_CNT_HIGH, '{32'h0, 32'h0, RESP_OKAY}, h2);
    t2 = $time;
    rd(ADDR_CNT_LOW, '{32'h0, 32'h0, RESP_OKAY}, l2);
    check(32'(16'({h2[7:0], l2[7:0]} - {h1[7:0], l1[7:0]})), 32'((t2 - t1) / 50),
      "count gap");
    wr(ADDR_STATUS, 32'h3, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check(32'(irq), 32'h0, "cleared irq");
    rd(ADDR_STATUS, '{32'h0, 32'h3, RESP_OKAY}, q);
    give_verdict();
  end
endmodule
